// *** design/pct_map.svh ***
// Register offsets, field positions, reset values and timing counts of one timer channel
`ifndef PCT_MAP_SVH
`define PCT_MAP_SVH

// Register word offsets (byte addresses)
`define PCT_OFS_CTRL      8'h00
`define PCT_OFS_PRESCALE  8'h04
`define PCT_OFS_COMPARE   8'h08
`define PCT_OFS_IRQ_EN    8'h0C
`define PCT_OFS_FLAG      8'h10
`define PCT_OFS_COUNTER   8'h14

// Control register fields
`define PCT_CTRL_RUN       0
`define PCT_CTRL_MODE_LO   4
`define PCT_CTRL_MODE_HI   5
`define PCT_CTRL_CONV_EN   8
`define PCT_CTRL_DMA_EN    10
`define PCT_CTRL_TRIG_SRC  11
`define PCT_CTRL_EVT_MODE  12
`define PCT_CTRL_EDGE_SEL  13
`define PCT_CTRL_DEBOUNCE  14
`define PCT_CTRL_CLK_LO    16
`define PCT_CTRL_CLK_HI    18

// Flag and enable bit
`define PCT_FLAG_MATCH     0

// Reset values
`define PCT_RST_WORD       32'h0000_0000
`define PCT_RST_COUNT      24'h00_0000
`define PCT_RST_TOGGLE     1'b1

// Debounce depth in clock cycles and number of clock sources
`define PCT_DEBOUNCE_CYC   3
`define PCT_NUM_CLK_SRC    6

`endif

// *** design/pct_pkg.sv ***
// Types shared by the timer channel
package pct_pkg;

   // Counting modes as held in the mode field
   typedef enum logic [1:0] {
      PCT_ONE_SHOT   = 2'b00,
      PCT_PERIODIC   = 2'b01,
      PCT_TOGGLE     = 2'b10,
      PCT_CONTINUOUS = 2'b11
   } pct_mode_t;

endpackage

// *** design/pct_timer.sv ***
// One prescaled compare timer channel with register port, event input and trigger outputs
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "pct_map.svh"

// What this block does
// - 8-bit prescaler, 24-bit counter, compare, one irq
// - Own clock source picked from six
// - One-shot mode counts once run bit set
// - One-shot match: flag, clear counter, stop
// - Flag and enable raise interrupt request
// - Periodic match: flag, clear, keep counting
// - Periodic repeats until run bit cleared
// - Toggle mode: periodic plus pin inversion
// - Toggle pin starts high, 50% duty
// - Continuous match: flag set, counter continues
// - Continuous counter wraps at 24-bit maximum
// - Compare rewritable while continuous counting runs
// - Live counter readable in bits 23:0
// - Event mode counts pin events, not ticks
// - Debounce filter switched by control bit 14
// - Control bit 13 selects counted edge
// - Event counting works in every mode
// - Interrupt request doubles as wake-up
// - Time-out triggers converter, DMA; capture never fires
// - Paired channels share one trigger line
// - Control bit 11 picks trigger source
// - Control bit 8 enables converter trigger
// - Control bit 10 enables DMA trigger
module pct_timer
   import pct_pkg::*;
#(
   parameter int ADDR_W  = 8,
   parameter int COUNT_W = 24,
   parameter int PRE_W   = 8
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [31:0]       wrData,
   input  wire logic              wrStrobe,
   input  wire logic              rdStrobe,
   output logic      [31:0]       rdData,
   input  wire logic [5:0]        srcTick,
   input  wire logic              eventInputPin,
   output logic                   toggleOutPin,
   output logic                   irqReq,
   output logic                   wakeReq,
   output logic                   adcTrig,
   output logic                   dmaTrig,
   output logic                   pairTrig
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic                run_reg;
   pct_mode_t           countModeSel_reg;
   logic                convTrigEn_reg;
   logic                dmaTrigEn_reg;
   logic                trigSrcSel_reg;
   logic                eventMode_reg;
   logic                eventEdgeSel_reg;
   logic                eventDebounceEn_reg;
   logic [2:0]          clkSrcSel_reg;
   logic [PRE_W-1:0]    prescaleDiv_reg;
   logic [PRE_W-1:0]    prescaleCount_reg;
   logic [COUNT_W-1:0]  compareValue_reg;
   logic [COUNT_W-1:0]  countValue_reg;
   logic                matchIrqEn_reg;
   logic                matchFlag_reg;
   logic                toggle_reg;
   logic [`PCT_DEBOUNCE_CYC-1:0] evtSamp_reg;
   logic                evtLevel_reg;
   logic                evtPrev_reg;
   logic                trigPulse_reg;
   logic [31:0]         rdData_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   // Write strobe qualified by register offset
   function automatic logic hitAddr(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hitAddr = (a == ADDR_W'(ofs));
   endfunction

   wire wrCtrl    = wrStrobe && hitAddr(regAddr, `PCT_OFS_CTRL);
   wire wrPre     = wrStrobe && hitAddr(regAddr, `PCT_OFS_PRESCALE);
   wire wrCmp     = wrStrobe && hitAddr(regAddr, `PCT_OFS_COMPARE);
   wire wrIen     = wrStrobe && hitAddr(regAddr, `PCT_OFS_IRQ_EN);
   wire wrFlag    = wrStrobe && hitAddr(regAddr, `PCT_OFS_FLAG);
   wire wrCount   = wrStrobe && hitAddr(regAddr, `PCT_OFS_COUNTER);
   wire flagClear = wrFlag && wrData[`PCT_FLAG_MATCH];

   ////////////////////////////////////////////////////////////////////////////
   // Clock source and prescaler

   // Kernel tick from the selected source; codes above five select nothing
   wire kernelTick = (clkSrcSel_reg < 3'(`PCT_NUM_CLK_SRC)) &&
                     srcTick[clkSrcSel_reg];
   wire prescWrap  = run_reg && kernelTick &&
                     (prescaleCount_reg == prescaleDiv_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Event input filter and edge detect

   // Debounce wants every sample equal, which is why the pin rate must stay low
   wire evtStable = (&evtSamp_reg) || !(|evtSamp_reg);
   wire evtLevelNext = eventDebounceEn_reg ?
                       (evtStable ? evtSamp_reg[0] : evtLevel_reg) :
                       evtSamp_reg[0];
   wire eventEdge = (evtLevel_reg != evtPrev_reg) &&
                    (evtLevel_reg == eventEdgeSel_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Counter advance and compare

   // Events replace prescaled ticks in any mode
   wire countAdvance = run_reg &&
                       (eventMode_reg ? eventEdge : prescWrap);
   wire [COUNT_W-1:0] countInc = COUNT_W'(countValue_reg + 1'b1);
   // Compare read live each cycle, so a new value takes effect at once
   wire matchHit = countAdvance && (countInc == compareValue_reg);
   wire autoClear = (countModeSel_reg != PCT_CONTINUOUS);
   wire autoStop  = (countModeSel_reg == PCT_ONE_SHOT);

   // No capture unit here, so the capture source never fires
   wire captureHit = 1'b0;
   wire trigEvent  = trigSrcSel_reg ? captureHit : matchHit;

   ////////////////////////////////////////////////////////////////////////////
   // Output decode

   assign irqReq       = matchFlag_reg && matchIrqEn_reg;
   assign wakeReq      = irqReq;
   assign adcTrig      = trigPulse_reg && convTrigEn_reg;
   assign dmaTrig      = trigPulse_reg && dmaTrigEn_reg;
   assign pairTrig     = trigPulse_reg;
   assign toggleOutPin = toggle_reg;
   assign rdData       = rdData_reg;

   // Read mux; unmapped offsets read zero
   logic [31:0] rdMux;
   always_comb begin
      rdMux = `PCT_RST_WORD;
      if (hitAddr(regAddr, `PCT_OFS_CTRL)) begin
         rdMux[`PCT_CTRL_RUN]                          = run_reg;
         rdMux[`PCT_CTRL_MODE_HI:`PCT_CTRL_MODE_LO]    = countModeSel_reg;
         rdMux[`PCT_CTRL_CONV_EN]                      = convTrigEn_reg;
         rdMux[`PCT_CTRL_DMA_EN]                       = dmaTrigEn_reg;
         rdMux[`PCT_CTRL_TRIG_SRC]                     = trigSrcSel_reg;
         rdMux[`PCT_CTRL_EVT_MODE]                     = eventMode_reg;
         rdMux[`PCT_CTRL_EDGE_SEL]                     = eventEdgeSel_reg;
         rdMux[`PCT_CTRL_DEBOUNCE]                     = eventDebounceEn_reg;
         rdMux[`PCT_CTRL_CLK_HI:`PCT_CTRL_CLK_LO]      = clkSrcSel_reg;
      end else if (hitAddr(regAddr, `PCT_OFS_PRESCALE)) begin
         rdMux[PRE_W-1:0] = prescaleDiv_reg;
      end else if (hitAddr(regAddr, `PCT_OFS_COMPARE)) begin
         rdMux[COUNT_W-1:0] = compareValue_reg;
      end else if (hitAddr(regAddr, `PCT_OFS_IRQ_EN)) begin
         rdMux[`PCT_FLAG_MATCH] = matchIrqEn_reg;
      end else if (hitAddr(regAddr, `PCT_OFS_FLAG)) begin
         rdMux[`PCT_FLAG_MATCH] = matchFlag_reg;
      end else if (hitAddr(regAddr, `PCT_OFS_COUNTER)) begin
         rdMux[COUNT_W-1:0] = countValue_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register; a software write beats the one-shot auto stop

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         run_reg             <= 1'b0;
         countModeSel_reg    <= PCT_ONE_SHOT;
         convTrigEn_reg      <= 1'b0;
         dmaTrigEn_reg       <= 1'b0;
         trigSrcSel_reg      <= 1'b0;
         eventMode_reg       <= 1'b0;
         eventEdgeSel_reg    <= 1'b0;
         eventDebounceEn_reg <= 1'b0;
         clkSrcSel_reg       <= 3'h0;
      end else if (wrCtrl) begin
         run_reg             <= wrData[`PCT_CTRL_RUN];
         countModeSel_reg    <= pct_mode_t'(wrData[`PCT_CTRL_MODE_HI:`PCT_CTRL_MODE_LO]);
         convTrigEn_reg      <= wrData[`PCT_CTRL_CONV_EN];
         dmaTrigEn_reg       <= wrData[`PCT_CTRL_DMA_EN];
         trigSrcSel_reg      <= wrData[`PCT_CTRL_TRIG_SRC];
         eventMode_reg       <= wrData[`PCT_CTRL_EVT_MODE];
         eventEdgeSel_reg    <= wrData[`PCT_CTRL_EDGE_SEL];
         eventDebounceEn_reg <= wrData[`PCT_CTRL_DEBOUNCE];
         clkSrcSel_reg       <= wrData[`PCT_CTRL_CLK_HI:`PCT_CTRL_CLK_LO];
      end else if (matchHit && autoStop) begin
         run_reg <= 1'b0;
      end
   end

   // Plain data registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         prescaleDiv_reg  <= '0;
         compareValue_reg <= `PCT_RST_COUNT;
         matchIrqEn_reg   <= 1'b0;
      end else begin
         if (wrPre) prescaleDiv_reg <= wrData[PRE_W-1:0];
         if (wrCmp) compareValue_reg <= wrData[COUNT_W-1:0];
         if (wrIen) matchIrqEn_reg <= wrData[`PCT_FLAG_MATCH];
      end
   end

   // Prescaler divides the kernel tick by divider plus one, idle while stopped
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !run_reg) begin
         prescaleCount_reg <= '0;
      end else if (kernelTick) begin
         prescaleCount_reg <= prescWrap ? '0 : PRE_W'(prescaleCount_reg + 1'b1);
      end
   end

   // Counter: auto clear in all but continuous mode; software load wins
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         countValue_reg <= `PCT_RST_COUNT;
      end else if (wrCount) begin
         countValue_reg <= wrData[COUNT_W-1:0];
      end else if (matchHit && autoClear) begin
         countValue_reg <= `PCT_RST_COUNT;
      end else if (countAdvance) begin
         countValue_reg <= countInc;
      end
   end

   // Sticky match flag; a new match beats a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         matchFlag_reg <= 1'b0;
      end else if (matchHit) begin
         matchFlag_reg <= 1'b1;
      end else if (flagClear) begin
         matchFlag_reg <= 1'b0;
      end
   end

   // Toggle pin starts high and flips on each match in toggle mode
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         toggle_reg <= `PCT_RST_TOGGLE;
      end else if (matchHit && countModeSel_reg == PCT_TOGGLE) begin
         toggle_reg <= !toggle_reg;
      end
   end

   // Event sampling, filtered level and previous level
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         evtSamp_reg  <= '0;
         evtLevel_reg <= 1'b0;
         evtPrev_reg  <= 1'b0;
      end else begin
         evtSamp_reg  <= {evtSamp_reg[`PCT_DEBOUNCE_CYC-2:0], eventInputPin};
         evtLevel_reg <= evtLevelNext;
         evtPrev_reg  <= evtLevel_reg;
      end
   end

   // Trigger pulse and read data
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         trigPulse_reg <= 1'b0;
         rdData_reg    <= `PCT_RST_WORD;
      end else begin
         trigPulse_reg <= trigEvent;
         rdData_reg    <= rdStrobe ? rdMux : `PCT_RST_WORD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Checks skip cycles where software rewrites the state that they watch

   oneshot_stop_a: assert property (matchHit && autoStop && !wrCtrl && !wrCount
      |=> !run_reg && countValue_reg == '0)
      else $error("one-shot match did not stop and clear");

   irq_level_a: assert property (matchHit && matchIrqEn_reg && !wrIen
      |=> irqReq)
      else $error("interrupt request missing after enabled match");

   periodic_clear_a: assert property (matchHit && countModeSel_reg == PCT_PERIODIC
      && !wrCtrl && !wrCount |=> run_reg && countValue_reg == '0)
      else $error("periodic match did not restart from zero");

   toggle_flip_a: assert property (matchHit && countModeSel_reg == PCT_TOGGLE
      |=> toggleOutPin != $past(toggleOutPin))
      else $error("toggle pin missed a match");

   cont_keep_a: assert property (matchHit && !autoClear && !wrCount
      |=> countValue_reg == $past(compareValue_reg))
      else $error("continuous match changed the count wrongly");

   flag_sticky_a: assert property (matchFlag_reg && !flagClear |=> matchFlag_reg)
      else $error("match flag dropped without a clear");

   halt_hold_a: assert property (!run_reg && !wrCount |=> $stable(countValue_reg))
      else $error("counter moved while stopped");

   presc_rate_a: assert property (countAdvance && !eventMode_reg |-> prescWrap)
      else $error("counter advanced without a prescaler wrap");

   read_count_a: assert property (rdStrobe && hitAddr(regAddr, `PCT_OFS_COUNTER)
      |=> rdData[COUNT_W-1:0] == $past(countValue_reg))
      else $error("counter read returned wrong value");

   conv_trig_a: assert property (matchHit && !trigSrcSel_reg && convTrigEn_reg
      && !wrCtrl |=> adcTrig)
      else $error("converter trigger missing after match");

   dma_trig_a: assert property (matchHit && !trigSrcSel_reg && dmaTrigEn_reg
      && !wrCtrl |=> dmaTrig)
      else $error("DMA trigger missing after match");

   pair_trig_a: assert property (matchHit && !trigSrcSel_reg
      |=> pairTrig)
      else $error("pair trigger missing after match");

   flag_clear_a: assert property (flagClear && !matchHit
      |=> !matchFlag_reg)
      else $error("match flag survived a clear");

   wake_req_a: assert property (matchHit && matchIrqEn_reg && !wrIen
      |=> wakeReq)
      else $error("wake request missing after enabled match");

   oneshot_c:  cover property (matchHit && countModeSel_reg == PCT_ONE_SHOT);
   periodic_c: cover property (matchHit && countModeSel_reg == PCT_PERIODIC ##[1:300] matchHit);
   toggle_c:   cover property (matchHit && countModeSel_reg == PCT_TOGGLE);
   event_c:    cover property (countAdvance && eventMode_reg);
   wrap_c:     cover property (countAdvance && !autoClear && countValue_reg == '1);

endmodule

// *** test/pct_event_src.sv ***
// Far-side model: the external source that drives the event input pin
`timescale 1ns/100ps
module pct_event_src (
   input  wire logic ref_clk,
   output logic      evPin
);
   // Pin rests low between bursts, so no stale level lingers
   initial evPin = 1'b0;

   // Width 5 or more keeps events under one eighth of the clock; width 1 is a glitch
   task automatic burst(input int n, input int w);
      repeat (n) begin
         evPin <= 1'b1;
         repeat (w) @(posedge ref_clk);
         evPin <= 1'b0;
         repeat (w) @(posedge ref_clk);
      end
   endtask
endmodule

// *** test/pct_timer_tb.sv ***
// Self-checking bench: register access, counting modes, event input and triggers
`timescale 1ns/100ps
`include "pct_map.svh"
module pct_timer_tb
   import pct_pkg::*;
;
   localparam logic [7:0] A_CTRL = `PCT_OFS_CTRL;
   localparam logic [7:0] A_PRE  = `PCT_OFS_PRESCALE;
   localparam logic [7:0] A_CMP  = `PCT_OFS_COMPARE;
   localparam logic [7:0] A_IEN  = `PCT_OFS_IRQ_EN;
   localparam logic [7:0] A_FLAG = `PCT_OFS_FLAG;
   localparam logic [7:0] A_VAL  = `PCT_OFS_COUNTER;
   logic        ref_clk;
   logic        rst_n;
   logic [7:0]  regAddr;
   logic [31:0] wrData;
   logic        wrStrobe;
   logic        rdStrobe;
   logic [31:0] rdData;
   logic [5:0]  srcTick;
   logic        eventInputPin;
   logic        toggleOutPin;
   logic        irqReq;
   logic        wakeReq;
   logic        adcTrig;
   logic        dmaTrig;
   logic        pairTrig;
   int          numErrors = 0;
   int          cmpCount = 0;
   int          adcCnt = 0;
   int          dmaCnt = 0;
   int          pairCnt = 0;

   ////////////////////////////////////////
   pct_timer DUT (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .wrData(wrData),
      .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .srcTick(srcTick),
      .eventInputPin(eventInputPin), .toggleOutPin(toggleOutPin), .irqReq(irqReq),
      .wakeReq(wakeReq), .adcTrig(adcTrig), .dmaTrig(dmaTrig), .pairTrig(pairTrig));
   pct_event_src evSrc (.ref_clk(ref_clk), .evPin(eventInputPin));

   // 20 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Trigger requests last one cycle, so each high sample is one request
   always @(posedge ref_clk) begin
      if (adcTrig === 1'b1) adcCnt++;
      if (dmaTrig === 1'b1) dmaCnt++;
      if (pairTrig === 1'b1) pairCnt++;
   end

   ////////////////////////////////////////
   // Compare tasks, one for words and one for pins
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         numErrors++;
         $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      cmpCount++;
      if (got !== exp) begin
         numErrors++;
         $display("MISMATCH t=%0t pin %b expected %b", $time, got, exp);
      end
   endtask

   // Bus cycles end one edge after the strobe drops, so no signal is set twice at one edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      regAddr  <= a;
      wrData   <= d;
      wrStrobe <= 1'b1;
      @(posedge ref_clk);
      wrStrobe <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      regAddr  <= a;
      rdStrobe <= 1'b1;
      @(posedge ref_clk);
      rdStrobe <= 1'b0;
      #1 chk32(rdData, exp);
      @(posedge ref_clk);
   endtask

   // Single-cycle pulses on one clock-source tick line
   task automatic tick(input int s, input int n);
      repeat (n) begin
         srcTick <= 6'h01 << s;
         @(posedge ref_clk);
         srcTick <= 6'h00;
         @(posedge ref_clk);
      end
   endtask

   // Control word from mode, clock source and loose bits
   function automatic logic [31:0] ctl(input logic [1:0] m, input logic [2:0] s,
                                       input logic [15:0] b);
      return {13'h0000, s, b | {10'h000, m, 4'h0}};
   endfunction

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
      if (numErrors == 0 && cmpCount > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Whole run needs under 2000 cycles; a hang is cut off well past that
   initial begin
      repeat (6000) @(posedge ref_clk);
      numErrors++;
      end_of_test();
   end

   ////////////////////////////////////////
   initial begin
      rst_n    = 1'b0;
      regAddr  = 8'h00;
      wrData   = 32'h0000_0000;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      srcTick  = 6'h00;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      // Reset state, unmapped word and field widths
      chk1(toggleOutPin, 1'b1);
      for (int i = 0; i < 7; i++) rdchk(8'(i * 4), 32'h0000_0000);
      wr(8'h18, 32'hFFFF_FFFF);
      rdchk(8'h18, 32'h0000_0000);
      wr(A_PRE, 32'hFFFF_FFFF);
      rdchk(A_PRE, 32'h0000_00FF);
      wr(A_CMP, 32'hFFFF_FFFF);
      rdchk(A_CMP, 32'h00FF_FFFF);
      // Only the selected source counts; divider 1 needs two ticks per advance
      wr(A_PRE, 32'h0000_0001);
      for (int s = 0; s < 6; s++) begin
         wr(A_CTRL, 32'h0000_0000);
         wr(A_VAL, 32'h0000_0000);
         wr(A_CTRL, ctl(PCT_CONTINUOUS, 3'(s), 16'h0001));
         tick((s + 1) % 6, 3);
         tick(s, 4);
         rdchk(A_VAL, 32'h0000_0002);
      end
      // Source code six selects no tick line, so the count holds
      wr(A_CTRL, ctl(PCT_CONTINUOUS, 3'h6, 16'h0001));
      tick(5, 4);
      rdchk(A_VAL, 32'h0000_0002);
      // One-shot stops itself at the match and drops the run bit
      wr(A_CTRL, 32'h0000_0000);
      wr(A_PRE, 32'h0000_0000);
      wr(A_VAL, 32'h0000_0000);
      wr(A_CMP, 32'h0000_0003);
      wr(A_CTRL, ctl(PCT_ONE_SHOT, 3'h0, 16'h0001));
      tick(0, 2);
      rdchk(A_VAL, 32'h0000_0002);
      tick(0, 3);
      rdchk(A_VAL, 32'h0000_0000);
      rdchk(A_CTRL, 32'h0000_0000);
      rdchk(A_FLAG, 32'h0000_0001);
      // Request follows flag and enable; only a written one clears the flag
      chk1(irqReq, 1'b0);
      wr(A_IEN, 32'h0000_0001);
      chk1(irqReq, 1'b1);
      chk1(wakeReq, 1'b1);
      wr(A_FLAG, 32'h0000_0000);
      chk1(irqReq, 1'b1);
      wr(A_FLAG, 32'h0000_0001);
      chk1(irqReq, 1'b0);
      rdchk(A_FLAG, 32'h0000_0000);
      // Periodic restarts at zero; the ungated pair line also carried the one-shot match
      wr(A_CTRL, ctl(PCT_PERIODIC, 3'h0, 16'h0501));
      tick(0, 11);
      chk32(32'(adcCnt), 32'h0000_0003);
      chk32(32'(dmaCnt), 32'h0000_0003);
      chk32(32'(pairCnt), 32'h0000_0004);
      rdchk(A_VAL, 32'h0000_0002);
      wr(A_CTRL, ctl(PCT_PERIODIC, 3'h0, 16'h0500));
      tick(0, 3);
      rdchk(A_VAL, 32'h0000_0002);
      // Capture chosen as trigger source: matches no longer reach converter or DMA
      wr(A_CTRL, ctl(PCT_PERIODIC, 3'h0, 16'h0D01));
      tick(0, 2);
      chk32(32'(adcCnt), 32'h0000_0003);
      chk32(32'(dmaCnt), 32'h0000_0003);
      rdchk(A_VAL, 32'h0000_0001);
      // Toggle pin flips at each match
      wr(A_CTRL, 32'h0000_0000);
      wr(A_VAL, 32'h0000_0000);
      wr(A_CMP, 32'h0000_0002);
      wr(A_CTRL, ctl(PCT_TOGGLE, 3'h0, 16'h0001));
      chk1(toggleOutPin, 1'b1);
      tick(0, 2);
      chk1(toggleOutPin, 1'b0);
      tick(0, 2);
      chk1(toggleOutPin, 1'b1);
      // Continuous wraps at the top, runs past the match, takes a new compare live
      wr(A_CTRL, 32'h0000_0000);
      wr(A_FLAG, 32'h0000_0001);
      wr(A_VAL, 32'h00FF_FFFE);
      wr(A_CMP, 32'h0000_0001);
      wr(A_CTRL, ctl(PCT_CONTINUOUS, 3'h0, 16'h0001));
      tick(0, 2);
      rdchk(A_VAL, 32'h0000_0000);
      rdchk(A_FLAG, 32'h0000_0000);
      tick(0, 2);
      rdchk(A_VAL, 32'h0000_0002);
      rdchk(A_FLAG, 32'h0000_0001);
      wr(A_FLAG, 32'h0000_0001);
      wr(A_CMP, 32'h0000_0004);
      tick(0, 2);
      rdchk(A_FLAG, 32'h0000_0001);
      // Rising edges counted, ticks ignored, an unfiltered glitch counts too
      wr(A_CTRL, 32'h0000_0000);
      wr(A_VAL, 32'h0000_0000);
      wr(A_CMP, 32'h00FF_FFFF);
      wr(A_CTRL, ctl(PCT_CONTINUOUS, 3'h0, 16'h3001));
      tick(0, 3);
      evSrc.burst(4, 5);
      evSrc.burst(1, 1);
      repeat (6) @(posedge ref_clk);
      rdchk(A_VAL, 32'h0000_0005);
      // Debounced falling edges in one-shot: glitch dropped, fourth edge matches
      wr(A_CTRL, 32'h0000_0000);
      wr(A_VAL, 32'h0000_0000);
      wr(A_FLAG, 32'h0000_0001);
      wr(A_CMP, 32'h0000_0004);
      wr(A_CTRL, ctl(PCT_ONE_SHOT, 3'h0, 16'h5001));
      evSrc.burst(3, 5);
      evSrc.burst(1, 1);
      repeat (6) @(posedge ref_clk);
      rdchk(A_VAL, 32'h0000_0003);
      evSrc.burst(1, 5);
      repeat (6) @(posedge ref_clk);
      rdchk(A_FLAG, 32'h0000_0001);
      rdchk(A_CTRL, 32'h0000_5000);
      end_of_test();
   end
endmodule
